// ==== hdl/mal_analog_latches.sv ====
`timescale 1ns/1ns
`default_nettype none

// Function
// - low two word bits pick strobed group
// - first group dc/ohms, second ac volts
// - range select low/high from q1/q2
// - q6 high inhibits all range mux channels
// - q2 high closes resistance relay
// - high-resistance bit: two off, one on
// - divider-common bit high opens divider common
// - four-wire bit low closes sense switch
// - aca low closes switches; shunts low-active
// - dc-coupling low: divider closed, aca open
// - test bit arms source, opens buffer
// - four relay bits close their relays
// - ac low selects complementary transistor pair
// - range bit high gives rectifier x10
// - peak bit low disables peak detect
// - extended bit low gives finer dac
// - q1..q8 drive dac code lsb..msb
// - three-bit code picks mux input two..eight
// - frequency bit arms counter, closes buffer
// - rms bit low: path closed, reset open
// - dac bit low routes dac to buffer
module mal_analog_latches (
    // clock and reset
    input  wire logic                    CLOCK_I,
    input  wire logic                    SRST_I,
    // word from the serial control interface
    input  wire mal_pkg::mal_word_t      WORD_I,
    input  wire logic                    WORD_VALID_I,
    // group strobes, registered on the same edge as the latch capture
    output logic                         DC_RES_STROBE_O,
    output logic                         AC_VOLT_STROBE_O,
    // raw latch contents
    output mal_pkg::mal_res_latch_t      RES_LATCH_O,
    output mal_pkg::mal_ac_latch_t       AC_LATCH_O,
    // resistance range latch
    output logic [1:0]                   RES_RANGE_SEL_O,
    output logic                         RES_RANGE_INHIBIT_O,
    // resistance path latch
    output logic                         RESISTANCE_RELAY_EN_O,
    output logic                         HIGH_RES_PATH_OFF_O,
    output logic                         HIGH_RES_PATH_ON_O,
    output logic                         DIVIDER_COMMON_ON_O,
    output logic                         FOUR_WIRE_SENSE_CLOSE_O,
    // current shunt latch
    output logic                         AC_CURRENT_SW_CLOSE_O,
    output logic [4:0]                   SHUNT_SEL_O,
    // ac path relay latch
    output logic                         DC_DIVIDER_SW_CLOSE_O,
    output logic                         DC_ACA_SW_CLOSE_O,
    output logic                         TEST_PATH_OFF_O,
    output logic                         TEST_SRC_ARM_O,
    output logic                         TEST_BUF_SW_OPEN_O,
    output logic                         TEST_FUNC_ARM_O,
    output logic [3:0]                   AC_RELAY_O,
    // ac range and peak latch
    output logic                         AC_LOW_XSTR_A_ON_O,
    output logic                         AC_LOW_XSTR_B_ON_O,
    output logic                         RECT_X10_O,
    output logic                         PEAK_DETECT_EN_O,
    output logic                         TRIG_LEVEL_FINE_O,
    // trigger level dac latch
    output logic [7:0]                   TRIG_LEVEL_CODE_O,
    // ac measurement select latch
    output logic [2:0]                   AC_MUX_SEL_O,
    output logic [7:0]                   AC_MUX_INPUT_O,
    output logic                         COUNTER_INPUT_ARM_O,
    output logic                         COUNTER_BUF_SW_CLOSE_O,
    output logic                         RMS_PATH_SW_CLOSE_O,
    output logic                         PEAK_RESET_SW_OPEN_O,
    output logic                         DAC_TO_AC_BUFFER_O
);

    logic [31:0] payload_ext;                      // payload, zero-padded
    logic        latch_strobe [mal_pkg::MAL_NUM_LATCH]; // per latch
    logic [7:0]  latch_d      [mal_pkg::MAL_NUM_LATCH]; // masked byte
    logic [7:0]  latch_q      [mal_pkg::MAL_NUM_LATCH]; // held byte
    logic        dc_resistance_strobe;             // resistance group hit
    logic        ac_voltage_strobe;                // ac group hit
    logic        dc_res_strobe_q;                  // delayed strobe
    logic        ac_volt_strobe_q;                 // delayed strobe
    mal_pkg::mal_res_latch_t res_latch;            // resistance group
    mal_pkg::mal_ac_latch_t  ac_latch;             // ac group

    // top two bits of the measure latch have no source bits; pad with zero
    assign payload_ext = {2'h0, WORD_I.payload};

    // group decode; gain-group and spare codes touch nothing here
    assign dc_resistance_strobe = WORD_VALID_I &&
        (WORD_I.target == mal_pkg::MAL_TGT_RES);
    assign ac_voltage_strobe = WORD_VALID_I &&
        (WORD_I.target == mal_pkg::MAL_TGT_AC);

    // one latch per table entry; bits outside the latch mask forced low
    genvar g;
    generate
        for (g = 0; g < mal_pkg::MAL_NUM_LATCH; g++) begin : g_latch
            // strobe only the latches of the addressed group
            assign latch_strobe[g] = WORD_VALID_I &&
                (WORD_I.target == mal_pkg::MAL_LATCH_TGT[g]);
            assign latch_d[g] =
                payload_ext[mal_pkg::MAL_LATCH_POS[g] +: 8] &
                mal_pkg::MAL_LATCH_MASK[g];
            mal_latch8 #(
                .RESET_VAL (mal_pkg::MAL_LATCH_RST[g])
            ) u_latch (
                .clk_i    (CLOCK_I),
                .srst_i   (SRST_I),
                .strobe_i (latch_strobe[g]),
                .d_i      (latch_d[g]),
                .q_o      (latch_q[g])
            );
        end
    endgenerate

    // strobe echoes, so the far end sees which group took the word
    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            dc_res_strobe_q  <= 1'b0;
            ac_volt_strobe_q <= 1'b0;
        end else begin
            dc_res_strobe_q  <= dc_resistance_strobe;
            ac_volt_strobe_q <= ac_voltage_strobe;
        end
    end

    assign DC_RES_STROBE_O  = dc_res_strobe_q;
    assign AC_VOLT_STROBE_O = ac_volt_strobe_q;

    // gather the latches into the two group records
    assign res_latch = {latch_q[2], latch_q[1], latch_q[0]};
    assign ac_latch  = {latch_q[6], latch_q[5], latch_q[4], latch_q[3]};
    assign RES_LATCH_O = res_latch;
    assign AC_LATCH_O  = ac_latch;

    // resistance range latch
    assign RES_RANGE_SEL_O = {res_latch.range[mal_pkg::MAL_RR_SEL_HI],
        res_latch.range[mal_pkg::MAL_RR_SEL_LO]};
    assign RES_RANGE_INHIBIT_O =
        res_latch.range[mal_pkg::MAL_RR_INHIBIT];

    // resistance path latch
    assign RESISTANCE_RELAY_EN_O =
        res_latch.path[mal_pkg::MAL_RP_RELAY];
    // high resistance swaps the two path transistors for the third
    assign HIGH_RES_PATH_OFF_O =
        res_latch.path[mal_pkg::MAL_RP_HIGH_RES];
    assign HIGH_RES_PATH_ON_O =
        res_latch.path[mal_pkg::MAL_RP_HIGH_RES];
    assign DIVIDER_COMMON_ON_O =
        !res_latch.path[mal_pkg::MAL_RP_DIV_N];
    assign FOUR_WIRE_SENSE_CLOSE_O =
        !res_latch.path[mal_pkg::MAL_RP_4W_N];

    // current shunt latch; several shunts at once is legal but unwise
    assign AC_CURRENT_SW_CLOSE_O =
        !res_latch.shunt[mal_pkg::MAL_SH_ACA_N];
    assign SHUNT_SEL_O = ~res_latch.shunt[mal_pkg::MAL_SH_SEL_LSB +:
        mal_pkg::MAL_SH_SEL_W];

    // ac path relay latch
    assign DC_DIVIDER_SW_CLOSE_O =
        !ac_latch.relay[mal_pkg::MAL_AR_DC_CPL];
    assign DC_ACA_SW_CLOSE_O =
        ac_latch.relay[mal_pkg::MAL_AR_DC_CPL];
    assign TEST_PATH_OFF_O =
        ac_latch.relay[mal_pkg::MAL_AR_TEST_ON];
    assign TEST_SRC_ARM_O =
        ac_latch.relay[mal_pkg::MAL_AR_TEST_ON];
    assign TEST_BUF_SW_OPEN_O =
        ac_latch.relay[mal_pkg::MAL_AR_TEST_ON];
    assign TEST_FUNC_ARM_O =
        ac_latch.relay[mal_pkg::MAL_AR_TEST_ARM];
    assign AC_RELAY_O =
        ac_latch.relay[mal_pkg::MAL_AR_RELAY_LSB +: 4];

    // ac range and peak latch; the pair is never on together
    assign AC_LOW_XSTR_A_ON_O =
        !ac_latch.range[mal_pkg::MAL_AG_LOW];
    assign AC_LOW_XSTR_B_ON_O =
        ac_latch.range[mal_pkg::MAL_AG_LOW];
    assign RECT_X10_O = ac_latch.range[mal_pkg::MAL_AG_X10];
    assign PEAK_DETECT_EN_O =
        ac_latch.range[mal_pkg::MAL_AG_PEAK_N];
    assign TRIG_LEVEL_FINE_O =
        !ac_latch.range[mal_pkg::MAL_AG_FINE];

    // trigger level dac, q1 is the least significant bit
    assign TRIG_LEVEL_CODE_O = ac_latch.dac;

    // ac measurement select latch; code zero selects no input
    assign AC_MUX_SEL_O = ac_latch.meas[mal_pkg::MAL_AM_SEL_LSB +: 3];
    assign AC_MUX_INPUT_O = (AC_MUX_SEL_O == 3'h0) ? 8'h00 :
        8'(8'h01 << AC_MUX_SEL_O);
    assign COUNTER_INPUT_ARM_O =
        ac_latch.meas[mal_pkg::MAL_AM_COUNTER_INPUT_ARM];
    assign COUNTER_BUF_SW_CLOSE_O =
        ac_latch.meas[mal_pkg::MAL_AM_COUNTER_INPUT_ARM];
    assign RMS_PATH_SW_CLOSE_O =
        !ac_latch.meas[mal_pkg::MAL_AM_RMS_N];
    assign PEAK_RESET_SW_OPEN_O =
        !ac_latch.meas[mal_pkg::MAL_AM_RMS_N];
    assign DAC_TO_AC_BUFFER_O =
        !ac_latch.meas[mal_pkg::MAL_AM_DAC_N];

    // checks on the captured state
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);

    // a word addressed to the resistance group
    sequence res_word_s;
        WORD_VALID_I && (WORD_I.target == mal_pkg::MAL_TGT_RES);
    endsequence

    // a word addressed to the ac group
    sequence ac_word_s;
        WORD_VALID_I && (WORD_I.target == mal_pkg::MAL_TGT_AC);
    endsequence

    // a word that misses the resistance group
    sequence res_miss_s;
        !(WORD_VALID_I && (WORD_I.target == mal_pkg::MAL_TGT_RES));
    endsequence

    // a word that misses the ac group
    sequence ac_miss_s;
        !(WORD_VALID_I && (WORD_I.target == mal_pkg::MAL_TGT_AC));
    endsequence

    group_route_a: assert property (
        res_word_s |=> DC_RES_STROBE_O && !AC_VOLT_STROBE_O)
        else $error("resistance word did not strobe only its group");

    ac_route_a: assert property (
        ac_word_s |=> AC_VOLT_STROBE_O && !DC_RES_STROBE_O &&
            (AC_LATCH_O.relay == $past(WORD_I.payload[7:0])))
        else $error("ac word did not land in the ac group");

    res_hold_a: assert property (
        res_miss_s |=> $stable(RES_LATCH_O))
        else $error("resistance group changed without its strobe");

    ac_hold_a: assert property (
        ac_miss_s |=> $stable(AC_LATCH_O))
        else $error("ac group changed without its strobe");

    range_sel_a: assert property (
        res_word_s |=> RES_RANGE_SEL_O == $past(WORD_I.payload[1:0]))
        else $error("range select not taken from q1 and q2");

    range_inhibit_a: assert property (
        res_word_s ##1 res_miss_s [*2] |->
            RES_RANGE_INHIBIT_O == $past(WORD_I.payload[5], 2))
        else $error("range inhibit does not follow q6");

    shunt_select_a: assert property (
        res_word_s |=> SHUNT_SEL_O == ~$past(WORD_I.payload[22:18]))
        else $error("shunt selects not low active");

    high_res_pair_a: assert property (
        res_word_s |=> HIGH_RES_PATH_ON_O == $past(WORD_I.payload[11]) &&
            HIGH_RES_PATH_OFF_O == HIGH_RES_PATH_ON_O)
        else $error("high resistance pair wrong");

    ac_low_pair_a: assert property (
        AC_LOW_XSTR_A_ON_O != AC_LOW_XSTR_B_ON_O)
        else $error("ac low transistors not complementary");

    dac_code_a: assert property (
        ac_word_s |=> TRIG_LEVEL_CODE_O == $past(WORD_I.payload[23:16]))
        else $error("trigger dac code not in bit order");

    mux_input_a: assert property (
        ac_word_s |=> AC_MUX_SEL_O == $past(WORD_I.payload[26:24]) &&
            $onehot0(AC_MUX_INPUT_O) &&
            (AC_MUX_INPUT_O[0] == 1'b0))
        else $error("mux select decode wrong");

    reset_value_a: assert property (
        $fell(SRST_I) |-> RES_LATCH_O == {mal_pkg::MAL_LATCH_RST[2],
            mal_pkg::MAL_LATCH_RST[1], mal_pkg::MAL_LATCH_RST[0]})
        else $error("resistance group not at reset value");

    // relay follows path q2
    res_relay_a: assert property (
        res_word_s |=> RESISTANCE_RELAY_EN_O == $past(WORD_I.payload[9]))
        else $error("resistance relay does not follow q2");

    // divider common on only while q5 is low
    div_common_a: assert property (
        res_word_s |=> DIVIDER_COMMON_ON_O == !$past(WORD_I.payload[12]))
        else $error("divider common does not follow q5");

    // sense switch closes on a low q7
    four_wire_a: assert property (
        res_word_s |=> FOUR_WIRE_SENSE_CLOSE_O == !$past(WORD_I.payload[14]))
        else $error("four-wire sense does not follow q7");

    // ac current switches close on a low shunt q1
    aca_path_a: assert property (
        res_word_s |=> AC_CURRENT_SW_CLOSE_O == !$past(WORD_I.payload[16]))
        else $error("ac current path does not follow q1");

    // dc coupling low closes divider, opens aca
    dc_coupling_a: assert property (
        ac_word_s |=> DC_DIVIDER_SW_CLOSE_O == !$past(WORD_I.payload[0]) &&
            DC_ACA_SW_CLOSE_O == $past(WORD_I.payload[0]))
        else $error("dc coupling switches wrong");

    // test bit drives three controls, arm bit one
    self_test_a: assert property (
        ac_word_s |=> {TEST_PATH_OFF_O, TEST_SRC_ARM_O, TEST_BUF_SW_OPEN_O,
            TEST_FUNC_ARM_O} == {{3{$past(WORD_I.payload[1])}},
            $past(WORD_I.payload[2])})
        else $error("internal test controls wrong");

    // relays follow q5 to q8 in order
    ac_relays_a: assert property (
        ac_word_s |=> AC_RELAY_O == $past(WORD_I.payload[7:4]))
        else $error("ac relays do not follow q5 to q8");

    // second low-range transistor follows q2
    ac_low_map_a: assert property (
        ac_word_s |=> AC_LOW_XSTR_B_ON_O == $past(WORD_I.payload[9]))
        else $error("ac low transistor does not follow q2");

    // rectifier gain follows q3
    rect_gain_a: assert property (
        ac_word_s |=> RECT_X10_O == $past(WORD_I.payload[10]))
        else $error("rectifier gain does not follow q3");

    // a low q4 disables peak detect
    peak_enable_a: assert property (
        ac_word_s |=> PEAK_DETECT_EN_O == $past(WORD_I.payload[11]))
        else $error("peak detect does not follow q4");

    // a low q6 selects the finer dac step
    trig_fine_a: assert property (
        ac_word_s |=> TRIG_LEVEL_FINE_O == !$past(WORD_I.payload[13]))
        else $error("trigger fine step does not follow q6");

    // counter arm and its buffer switch follow q4
    counter_arm_a: assert property (
        ac_word_s |=> COUNTER_INPUT_ARM_O == $past(WORD_I.payload[27]) &&
            COUNTER_BUF_SW_CLOSE_O == COUNTER_INPUT_ARM_O)
        else $error("counter arm does not follow q4");

    // a low q5 closes the rms path, opens peak reset
    rms_path_a: assert property (
        ac_word_s |=> RMS_PATH_SW_CLOSE_O == !$past(WORD_I.payload[28]) &&
            PEAK_RESET_SW_OPEN_O == RMS_PATH_SW_CLOSE_O)
        else $error("rms path switches wrong");

    // a low q6 routes the dac to the buffer
    dac_route_a: assert property (
        ac_word_s |=> DAC_TO_AC_BUFFER_O == !$past(WORD_I.payload[29]))
        else $error("dac route does not follow q6");

endmodule // mal_analog_latches

`default_nettype wire

// ==== hdl/mal_latch8.sv ====
`timescale 1ns/1ns
`default_nettype none

// one 8-bit strobed latch, holds until its own strobe fires
module mal_latch8 #(
    parameter logic [7:0] RESET_VAL = 8'h00  // value after reset
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // capture side
    input  wire logic       strobe_i,
    input  wire logic [7:0] d_i,
    // latch outputs
    output logic      [7:0] q_o
);

    logic [7:0] q_q;  // captured byte

    // capture on strobe, otherwise hold the old value
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_q <= RESET_VAL;
        end else if (strobe_i) begin
            q_q <= d_i;
        end
    end

    assign q_o = q_q;

endmodule // mal_latch8

`default_nettype wire

// ==== hdl/mal_pkg.sv ====
`default_nettype none

package mal_pkg;

    // one configuration word from the serial control interface
    typedef struct packed {
        logic [29:0] payload;  // latch bytes, lowest latch first
        logic [1:0]  target;   // picks the latch group to strobe
    } mal_word_t;

    // resistance / dc-voltage latch group, as captured
    typedef struct packed {
        logic [7:0] shunt;     // current-shunt latch
        logic [7:0] path;      // resistance path latch
        logic [7:0] range;     // resistance range latch
    } mal_res_latch_t;

    // ac-voltage latch group, as captured
    typedef struct packed {
        logic [7:0] meas;      // ac measurement select latch
        logic [7:0] dac;       // trigger-level dac code latch
        logic [7:0] range;     // ac range and peak latch
        logic [7:0] relay;     // ac path relay latch
    } mal_ac_latch_t;

    // target codes in the two low bits of the word
    localparam logic [1:0] MAL_TGT_GAIN = 2'h0;  // a/d and gain group
    localparam logic [1:0] MAL_TGT_RES  = 2'h1;  // resistance / dc group
    localparam logic [1:0] MAL_TGT_AC   = 2'h2;  // ac-voltage group

    // latch table, index 0..2 resistance group, 3..6 ac group
    localparam int         MAL_NUM_LATCH = 7;
    localparam int         MAL_LATCH_POS [MAL_NUM_LATCH] =
        '{0, 8, 16, 0, 8, 16, 24};
    localparam logic [1:0] MAL_LATCH_TGT [MAL_NUM_LATCH] =
        '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
    localparam logic [7:0] MAL_LATCH_MASK [MAL_NUM_LATCH] =
        '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h3f};
    // after reset: active-low controls idle high, relays open
    localparam logic [7:0] MAL_LATCH_RST [MAL_NUM_LATCH] =
        '{8'h20, 8'hf0, 8'h7f, 8'h09, 8'h19, 8'h00, 8'h30};

    // bit positions inside the latches (q1 is bit 0)
    localparam int MAL_RR_SEL_LO   = 0;  // range select low
    localparam int MAL_RR_SEL_HI   = 1;  // range select high
    localparam int MAL_RR_INHIBIT  = 5;  // range mux inhibit
    localparam int MAL_RP_RELAY    = 1;  // resistance relay
    localparam int MAL_RP_HIGH_RES = 3;  // high resistance select
    localparam int MAL_RP_DIV_N    = 4;  // divider common, low active
    localparam int MAL_RP_4W_N     = 6;  // four-wire sense, low active
    localparam int MAL_SH_ACA_N    = 0;  // ac current path, low active
    localparam int MAL_SH_SEL_LSB  = 2;  // first shunt select
    localparam int MAL_SH_SEL_W    = 5;  // number of shunts
    localparam int MAL_AR_DC_CPL   = 0;  // dc coupling select
    localparam int MAL_AR_TEST_ON  = 1;  // internal test on
    localparam int MAL_AR_TEST_ARM = 2;  // internal test arm
    localparam int MAL_AR_RELAY_LSB = 4; // first ac relay
    localparam int MAL_AG_LOW      = 1;  // ac low range
    localparam int MAL_AG_X10      = 2;  // rectifier x10
    localparam int MAL_AG_PEAK_N   = 3;  // peak detect, low disables
    localparam int MAL_AG_FINE     = 5;  // trigger level extended
    localparam int MAL_AM_SEL_LSB  = 0;  // mux select field
    localparam int MAL_AM_COUNTER_INPUT_ARM     = 3;  // counter input arm
    localparam int MAL_AM_RMS_N    = 4;  // rms path, low active
    localparam int MAL_AM_DAC_N    = 5;  // dac route, low active

endpackage : mal_pkg

`default_nettype wire

// ==== tb/mal_word_src.sv ====
`timescale 1ns/1ns
`default_nettype none

// model of the serial control interface feeding the latch bank
module mal_word_src (
    // clock
    input  wire logic          clk_i,
    // word towards the latch bank
    output mal_pkg::mal_word_t word_o,
    output logic               valid_o
);
    // idle at time zero: nothing offered
    initial begin
        word_o  = '0;
        valid_o = 1'b0;
    end

    // offer one 32-bit word; the low two bits pick the group
    // hold keeps valid up so the next call lands back to back
    task automatic send(input mal_pkg::mal_word_t w, input bit hold);
        @(posedge clk_i);
        word_o  <= w;
        valid_o <= 1'b1;
        if (!hold) begin
            @(posedge clk_i);
            valid_o <= 1'b0;
            // released bus shows inverted bits, not the stale word
            word_o  <= ~w;
        end
    endtask
endmodule // mal_word_src

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`default_nettype none

// self-checking bench for the analog control latch bank
module tb;
    logic                    clk, srst;      // clock and sync reset
    mal_pkg::mal_word_t      word;           // word from the model
    logic                    valid;          // word qualifier
    logic                    dc_stb, ac_stb; // group strobe echoes
    mal_pkg::mal_res_latch_t res_q;          // raw resistance group
    mal_pkg::mal_ac_latch_t  ac_q;           // raw ac group
    logic [1:0]              rr_sel;
    logic                    rr_inh, rel_en, hr_off, hr_on, div_on;
    logic                    fw_cl, aca_cl, dcdiv, dcaca;
    logic                    t_off, t_arm, t_buf, t_func;
    logic [4:0]              shunt;
    logic [3:0]              relay;
    logic                    xa, xb, x10, pk_en, fine;
    logic [7:0]              trig, mux_in;
    logic [2:0]              mux_sel;
    logic                    c_arm, c_buf, rms_cl, pkr_op, dac_buf;
    logic [7:0]              e_r, e_p, e_s, e_rl, e_rg, e_d, e_m;
    int                      n_dc, n_ac;     // strobe pulses seen
    int                      mismatches, n_compared;

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // far side of the word port
    mal_word_src src (.clk_i(clk), .word_o(word), .valid_o(valid));

    mal_analog_latches dut (
        .CLOCK_I(clk), .SRST_I(srst), .WORD_I(word), .WORD_VALID_I(valid),
        .DC_RES_STROBE_O(dc_stb), .AC_VOLT_STROBE_O(ac_stb),
        .RES_LATCH_O(res_q), .AC_LATCH_O(ac_q),
        .RES_RANGE_SEL_O(rr_sel), .RES_RANGE_INHIBIT_O(rr_inh),
        .RESISTANCE_RELAY_EN_O(rel_en), .HIGH_RES_PATH_OFF_O(hr_off),
        .HIGH_RES_PATH_ON_O(hr_on), .DIVIDER_COMMON_ON_O(div_on),
        .FOUR_WIRE_SENSE_CLOSE_O(fw_cl), .AC_CURRENT_SW_CLOSE_O(aca_cl),
        .SHUNT_SEL_O(shunt), .DC_DIVIDER_SW_CLOSE_O(dcdiv),
        .DC_ACA_SW_CLOSE_O(dcaca), .TEST_PATH_OFF_O(t_off),
        .TEST_SRC_ARM_O(t_arm), .TEST_BUF_SW_OPEN_O(t_buf),
        .TEST_FUNC_ARM_O(t_func), .AC_RELAY_O(relay),
        .AC_LOW_XSTR_A_ON_O(xa), .AC_LOW_XSTR_B_ON_O(xb),
        .RECT_X10_O(x10), .PEAK_DETECT_EN_O(pk_en),
        .TRIG_LEVEL_FINE_O(fine), .TRIG_LEVEL_CODE_O(trig),
        .AC_MUX_SEL_O(mux_sel), .AC_MUX_INPUT_O(mux_in),
        .COUNTER_INPUT_ARM_O(c_arm), .COUNTER_BUF_SW_CLOSE_O(c_buf),
        .RMS_PATH_SW_CLOSE_O(rms_cl), .PEAK_RESET_SW_OPEN_O(pkr_op),
        .DAC_TO_AC_BUFFER_O(dac_buf)
    );

    // count one-cycle strobe pulses mid-cycle, where they are settled
    always @(negedge clk) begin
        if (dc_stb === 1'b1) n_dc++;
        if (ac_stb === 1'b1) n_ac++;
    end

    // single comparison point
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // every latch and decoded output against the expected state
    task automatic chk_state();
        chk("res_latch", res_q, {e_s, e_p, e_r});
        chk("ac_latch", ac_q, {e_m, e_d, e_rg, e_rl});
        chk("range_sel", rr_sel, e_r[1:0]);
        chk("inhibit", rr_inh, e_r[5]);
        chk("res_relay", rel_en, e_p[1]);
        chk("high_res", {hr_off, hr_on}, {2{e_p[3]}});
        chk("div_common", div_on, {~e_p[4]});
        chk("four_wire", fw_cl, {~e_p[6]});
        chk("shunts", {aca_cl, shunt}, {~{e_s[0], e_s[6:2]}});
        chk("dc_cpl", {dcdiv, dcaca}, {~e_rl[0], e_rl[0]});
        chk("internal_test_on", {t_off, t_arm, t_buf, t_func},
            {{3{e_rl[1]}}, e_rl[2]});
        chk("ac_relays", relay, e_rl[7:4]);
        chk("ac_low", {xa, xb}, {~e_rg[1], e_rg[1]});
        chk("rect_x10", x10, e_rg[2]);
        chk("peak_en", pk_en, e_rg[3]);
        chk("trig_fine", fine, {~e_rg[5]});
        chk("trig_code", trig, e_d);
        chk("mux", {mux_sel, mux_in}, {e_m[2:0], (e_m[2:0] == 3'h0) ?
            8'h00 : 8'h01 << e_m[2:0]});
        chk("counter_input_arm", {c_arm, c_buf}, {2{e_m[3]}});
        chk("rms", {rms_cl, pkr_op}, {2{~e_m[4]}});
        chk("dac_route", dac_buf, {~e_m[5]});
    endtask

    // resistance word; unused top payload bits carry junk on purpose
    task automatic put_res(input logic [7:0] r, p, s, input bit hold);
        e_r = r;
        e_p = p;
        e_s = s & 8'h7f;
        src.send({6'h2a, s, p, r, 2'h1}, hold);
        if (!hold) begin
            @(negedge clk);
            #1;
        end
    endtask

    // ac word; meas latch keeps only six bits
    task automatic put_ac(input logic [7:0] rl, rg, d, m, input bit hold);
        e_rl = rl;
        e_rg = rg;
        e_d  = d;
        e_m  = m & 8'h3f;
        src.send({m[5:0], d, rg, rl, 2'h2}, hold);
        if (!hold) begin
            @(negedge clk);
            #1;
        end
    endtask

    // reset state: active-low controls idle high, relays open
    task automatic t_reset_vals();
        {e_s, e_p, e_r} = 24'h7ff020;
        {e_m, e_d, e_rg, e_rl} = 32'h30001909;
        chk_state();
    endtask

    // resistance group in two complementary patterns, ac group untouched
    task automatic t_res();
        int d0;
        int a0;
        for (int i = 0; i < 2; i++) begin
            d0 = n_dc;
            a0 = n_ac;
            put_res(i ? 8'h5a : 8'ha5, i ? 8'hc3 : 8'h3c, i ? 8'h96 : 8'h69,
                    1'b0);
            chk_state();
            chk("dc_strobes", n_dc - d0, 1);
            chk("ac_strobes", n_ac - a0, 0);
        end
    endtask

    // ac group in two complementary patterns, resistance group untouched
    task automatic t_ac();
        int d0;
        int a0;
        for (int i = 0; i < 2; i++) begin
            d0 = n_dc;
            a0 = n_ac;
            put_ac(i ? 8'h5a : 8'ha5, i ? 8'hc3 : 8'h3c, i ? 8'h81 : 8'h7e,
                   i ? 8'hd5 : 8'h2a, 1'b0);
            chk_state();
            chk("ac_strobes", n_ac - a0, 1);
            chk("dc_strobes", n_dc - d0, 0);
        end
    endtask

    // every multiplexer code, upper meas bits walking along
    task automatic t_mux();
        for (int k = 0; k < 8; k++) begin
            put_ac(e_rl, e_rg, e_d, {5'(k + 3), 3'(k)}, 1'b0);
            chk_state();
        end
    endtask

    // gain-group and spare target codes must change nothing
    task automatic t_refuse();
        int d0;
        int a0;
        d0 = n_dc;
        a0 = n_ac;
        src.send({30'h3fffffff, 2'h0}, 1'b0);
        src.send({30'h3fffffff, 2'h3}, 1'b0);
        @(negedge clk);
        #1;
        chk_state();
        chk("no_strobe", (n_dc - d0) + (n_ac - a0), 0);
    endtask

    // back-to-back words, the last one overwriting the first
    task automatic t_b2b();
        int d0;
        int a0;
        d0 = n_dc;
        a0 = n_ac;
        put_res(8'h11, 8'h22, 8'h44, 1'b1);
        put_ac(8'hf0, 8'h0f, 8'h33, 8'h17, 1'b1);
        put_res(8'hee, 8'hdd, 8'hbb, 1'b0);
        chk_state();
        chk("b2b_dc", n_dc - d0, 2);
        chk("b2b_ac", n_ac - a0, 1);
    endtask

    // reset in mid-run restores idle values; first word right after
    task automatic t_midreset();
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        t_reset_vals();
        put_res(8'h03, 8'h0a, 8'h01, 1'b0);
        chk_state();
    endtask

    // hang guard
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    // main sequence
    initial begin
        srst = 1'b1;
        mismatches = 0;
        n_compared = 0;
        n_dc = 0;
        n_ac = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        #1;
        t_reset_vals();
        t_res();
        t_ac();
        t_mux();
        t_refuse();
        t_b2b();
        t_midreset();
        end_sim();
    end
endmodule // tb

`default_nettype wire
